// [emb_regs.vh]
// constants for the external memory bus block
`ifndef EMB_REGS_VH
`define EMB_REGS_VH
`define EMB_ADDR_CTRL        32'h0000_0000
`define EMB_ADDR_STATUS      32'h0000_0004
`define EMB_ADDR_HOLD        32'h0000_0008
`define EMB_WM_LSB           0
`define EMB_WM_W             2
`define EMB_WAIT_LSB         4
`define EMB_WAIT_W           2
`define EMB_WAITEN_BIT       6
`define EMB_BUS8_BIT         7
`define EMB_CTRL_RST         8'h30
`define EMB_WM_BYTE_WRITE    2'h0
`define EMB_WM_WORD_WRITE    2'h1
`define EMB_WM_BYTE_SELECT   2'h2
`define EMB_PH_CYCLES        2
`define EMB_TCY_CYCLES       8
`endif

// [emb_bus.v]
// external memory bus engine with ahb-lite control registers
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "emb_regs.vh"

module emb_bus #(
    parameter TCY = `EMB_TCY_CYCLES
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        haddr_sel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        op_req,
    input  wire        op_write,
    input  wire        op_fetch,
    input  wire [20:0] table_pointer,
    input  wire [7:0]  table_latch_byte,
    output reg         op_done,
    output reg  [15:0] op_rdata,
    input  wire        sleep_req,
    input  wire [15:0] bus_in,
    output reg  [15:0] muxed_bus_lines,
    output reg  [15:0] bus_oe_n,
    output reg         addr_latch,
    output reg         chip_enable_n,
    output reg         output_enable_n,
    output reg         write_high_strobe_n,
    output reg         write_low_strobe_n,
    output reg         byte_address_lsb,
    output reg         upper_byte_select_n,
    output reg         lower_byte_select_n
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_DATA = 3'h2;
    localparam ST_DAT2 = 3'h3;
    localparam ST_WAIT = 3'h4;
    localparam ST_DONE = 3'h5;

    reg  [15:0] bus_s1;
    reg  [15:0] bus_s2;
    reg  [7:0]  ctrl;
    reg  [7:0]  hold_byte;
    reg         hold_valid;

    reg  [2:0]  state;
    reg  [7:0]  cnt;
    reg  [1:0]  wcnt;
    reg         cur_wr;
    reg         cur_fetch;
    reg  [20:0] cur_ptr;
    reg  [7:0]  cur_lat;

    reg         ph_pend;
    reg         ph_wr;
    reg  [31:0] ph_addr;
    reg         frozen;

    wire [31:0] half_full;
    wire [7:0]  half;
    wire [1:0]  wmode;
    wire [1:0]  wait_n;
    wire        wait_en;
    wire        bus8;
    wire        mode_word;
    wire        mode_bsel;
    wire        word_wr;
    wire        even_wr;
    wire        ahb_take;
    wire        addr_done;
    wire        ph_done;
    wire        tcy_done;
    wire [2:0]  after_data;
    reg  [31:0] next_rdata;

    // mode and phase decode
    assign half_full  = TCY / 2;
    assign half       = half_full[7:0];
    assign wmode      = ctrl[`EMB_WM_LSB +: `EMB_WM_W];
    assign wait_n     = ctrl[`EMB_WAIT_LSB +: `EMB_WAIT_W];
    assign wait_en    = ctrl[`EMB_WAITEN_BIT];
    assign bus8       = ctrl[`EMB_BUS8_BIT];
    assign mode_word  = (wmode == `EMB_WM_WORD_WRITE);
    assign mode_bsel  = (wmode == `EMB_WM_BYTE_SELECT);
    assign word_wr    = cur_wr && !bus8 && mode_word;
    assign even_wr    = word_wr && !cur_ptr[0];
    assign ahb_take   = haddr_sel && htrans[1] && hready;
    assign addr_done  = (cnt == `EMB_PH_CYCLES - 1);
    assign ph_done    = (cnt == half - 8'h01);
    assign tcy_done   = (cnt == TCY - 1);
    assign after_data = (wait_en && wait_n != 2'h0) ? ST_WAIT : ST_DONE;

    // pin sampler, two flops per line
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_sync
            always @(posedge clk) begin
                bus_s1[gi] <= bus_in[gi];
                bus_s2[gi] <= bus_s1[gi];
            end
        end
    endgenerate

    // register read mux
    always @* begin
        next_rdata = 32'h0000_0000;
        case (haddr)
            `EMB_ADDR_CTRL:   next_rdata = {24'h000000, ctrl};
            `EMB_ADDR_STATUS: next_rdata = {27'h0000000, frozen, hold_valid, state};
            `EMB_ADDR_HOLD:   next_rdata = {24'h000000, hold_byte};
            default:          next_rdata = 32'h0000_0000;
        endcase
    end

    // ahb-lite slave, zero wait, always okay
    always @(posedge clk) begin
        if (!rst_n) begin
            ph_pend   <= 1'b0;
            ph_wr     <= 1'b0;
            ph_addr   <= 32'h0000_0000;
            ctrl      <= `EMB_CTRL_RST;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            ph_pend   <= ahb_take;
            ph_wr     <= hwrite;
            ph_addr   <= haddr;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;

            // write lands in the data phase
            if (ph_pend && ph_wr && ph_addr == `EMB_ADDR_CTRL) begin
                ctrl <= hwdata[7:0];
            end
            // read data stands through the data phase
            if (ahb_take && !hwrite) begin
                hrdata <= next_rdata;
            end
        end
    end

    // bus sequencer
    always @(posedge clk) begin
        if (!rst_n) begin
            state               <= ST_IDLE;
            cnt                 <= 8'h00;
            wcnt                <= 2'h0;
            cur_wr              <= 1'b0;
            cur_fetch           <= 1'b0;
            cur_ptr             <= 21'h000000;
            cur_lat             <= 8'h00;
            hold_byte           <= 8'h00;
            hold_valid          <= 1'b0;
            frozen              <= 1'b0;
            op_done             <= 1'b0;
            op_rdata            <= 16'h0000;

            muxed_bus_lines     <= 16'h0000;
            bus_oe_n            <= 16'hffff;
            addr_latch          <= 1'b0;
            chip_enable_n       <= 1'b1;
            output_enable_n     <= 1'b1;
            write_high_strobe_n <= 1'b1;
            write_low_strobe_n  <= 1'b1;
            byte_address_lsb    <= 1'b0;
            upper_byte_select_n <= 1'b1;
            lower_byte_select_n <= 1'b1;
        end else if (sleep_req) begin
            // freeze pins; only enable and byte selects go high
            frozen              <= 1'b1;
            op_done             <= 1'b0;
            chip_enable_n       <= 1'b1;
            upper_byte_select_n <= 1'b1;
            lower_byte_select_n <= 1'b1;
        end else begin
            frozen  <= 1'b0;
            op_done <= 1'b0;
            // timing counts in clk cycles, so slower clocks scale it
            cnt <= cnt + 8'h01;
            case (state)
                ST_IDLE: begin
                    // internal execution: lines released, strobes parked
                    bus_oe_n            <= 16'hffff;
                    addr_latch          <= 1'b0;
                    byte_address_lsb    <= 1'b0;
                    chip_enable_n       <= 1'b1;
                    output_enable_n     <= 1'b1;
                    write_high_strobe_n <= 1'b1;
                    write_low_strobe_n  <= 1'b1;
                    upper_byte_select_n <= 1'b1;
                    lower_byte_select_n <= 1'b1;

                    if (op_req) begin
                        cur_wr    <= op_write;
                        cur_fetch <= op_fetch && !op_write;
                        cur_ptr   <= table_pointer;
                        cur_lat   <= table_latch_byte;
                        cnt       <= 8'h00;
                        state     <= ST_ADDR;
                    end
                end

                ST_ADDR: begin
                    muxed_bus_lines  <= cur_ptr[16:1];
                    bus_oe_n         <= 16'h0000;
                    addr_latch       <= 1'b1;
                    chip_enable_n    <= 1'b0;
                    byte_address_lsb <= cur_ptr[0];
                    if (bus8) begin
                        byte_address_lsb <= cur_fetch ? 1'b0 : cur_ptr[0];
                    end
                    if (addr_done) begin
                        addr_latch <= 1'b0;
                        cnt        <= 8'h00;
                        state      <= ST_DATA;
                    end
                end

                ST_DATA: begin
                    chip_enable_n <= 1'b0;
                    if (cur_wr) begin
                        if (bus8) begin
                            // narrow bus: data on low eight lines
                            muxed_bus_lines[7:0] <= cur_lat;
                            bus_oe_n             <= 16'hff00;
                            write_high_strobe_n  <= 1'b0;
                        end else if (mode_word) begin
                            if (even_wr) begin
                                bus_oe_n <= 16'hffff;
                            end else begin
                                muxed_bus_lines     <= {cur_lat, hold_byte};
                                bus_oe_n            <= 16'h0000;
                                write_high_strobe_n <= 1'b0;
                                upper_byte_select_n <= 1'b0;
                                lower_byte_select_n <= 1'b0;
                            end
                        end else if (mode_bsel) begin
                            muxed_bus_lines     <= {cur_lat, cur_lat};
                            bus_oe_n            <= 16'h0000;
                            write_high_strobe_n <= 1'b0;
                            upper_byte_select_n <= !cur_ptr[0];
                            lower_byte_select_n <= cur_ptr[0];
                        end else begin
                            muxed_bus_lines     <= {cur_lat, cur_lat};
                            bus_oe_n            <= 16'h0000;
                            write_high_strobe_n <= cur_ptr[0];
                            write_low_strobe_n  <= !cur_ptr[0];
                        end
                    end else begin
                        bus_oe_n            <= 16'hffff;
                        output_enable_n     <= 1'b0;
                        upper_byte_select_n <= 1'b0;
                        lower_byte_select_n <= 1'b0;
                    end

                    if (ph_done) begin
                        cnt <= 8'h00;
                        if (!cur_wr) begin
                            op_rdata <= bus8 ? {8'h00, bus_s2[7:0]} : bus_s2;
                        end
                        if (even_wr) begin
                            hold_byte  <= cur_lat;
                            hold_valid <= 1'b1;
                        end else if (word_wr) begin
                            hold_valid <= 1'b0;
                        end
                        write_high_strobe_n <= 1'b1;
                        write_low_strobe_n  <= 1'b1;
                        if (bus8 && cur_fetch) begin
                            byte_address_lsb <= 1'b1;
                            state            <= ST_DAT2;
                        end else begin
                            wcnt  <= wait_n;
                            state <= after_data;
                        end
                    end
                end

                ST_DAT2: begin
                    chip_enable_n <= 1'b0;
                    if (ph_done) begin
                        op_rdata[15:8] <= bus_s2[7:0];
                        cnt            <= 8'h00;
                        wcnt           <= wait_n;
                        state          <= after_data;
                    end
                end

                ST_WAIT: begin
                    // added instruction cycles after the table op
                    chip_enable_n <= 1'b0;
                    if (tcy_done) begin
                        cnt  <= 8'h00;
                        wcnt <= wcnt - 2'h1;
                        if (wcnt == 2'h1) begin
                            state <= ST_DONE;
                        end
                    end
                end

                ST_DONE: begin
                    op_done <= 1'b1;
                    state   <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

// [emb_mem_model.sv]
// word-wide external memory model on the multiplexed bus
`timescale 1ns/1ps
module emb_mem_model (
    input  wire        clk,
    input  wire [15:0] muxed_bus_lines,
    input  wire        addr_latch,
    input  wire        chip_enable_n,
    input  wire        output_enable_n,
    input  wire        write_high_strobe_n,
    input  wire        byte_address_lsb,
    input  wire        upper_byte_select_n,
    input  wire        lower_byte_select_n,
    output wire [15:0] bus_in
);
    reg [15:0] mem [0:255];
    reg [7:0]  adr = 8'h00;
    wire [15:0] rd_word;
    integer    i;
    initial begin
        for (i = 0; i < 256; i = i + 1) mem[i] = 16'h0000;
    end
    // read data while chip enable and output enable are both low, inverse pattern otherwise
    assign rd_word = byte_address_lsb ? {mem[adr][7:0], mem[adr][15:8]} : mem[adr];
    assign bus_in = (!chip_enable_n && !output_enable_n) ? rd_word : ~rd_word;
    always @(posedge clk) begin
        if (addr_latch) adr <= muxed_bus_lines[7:0];
        if (!chip_enable_n && !write_high_strobe_n && !upper_byte_select_n)
            mem[adr][15:8] <= muxed_bus_lines[15:8];
        if (!chip_enable_n && !write_high_strobe_n && !lower_byte_select_n)
            mem[adr][7:0] <= muxed_bus_lines[7:0];
    end
endmodule

// [emb_bus_sva.sv]
// assertions on the external memory bus ports
`timescale 1ns/1ps
`include "emb_regs.vh"
module emb_bus_sva #(
    parameter TCY = 8
) (
    input wire        clk,
    input wire        rst_n,
    input wire        haddr_sel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        op_req,
    input wire        op_write,
    input wire [20:0] table_pointer,
    input wire [7:0]  table_latch_byte,
    input wire        op_done,
    input wire        sleep_req,
    input wire [15:0] muxed_bus_lines,
    input wire [15:0] bus_oe_n,
    input wire        addr_latch,
    input wire        chip_enable_n,
    input wire        output_enable_n,
    input wire        write_high_strobe_n,
    input wire        write_low_strobe_n,
    input wire        byte_address_lsb,
    input wire        upper_byte_select_n,
    input wire        lower_byte_select_n
);
    localparam int DMAX = 4 * TCY + 40;
    reg  [7:0] ctrl;
    reg  [7:0] held;
    reg        cw;
    reg        even_op;
    wire       ww = ctrl[1:0] == `EMB_WM_WORD_WRITE;
    wire       bs = ctrl[1:0] == `EMB_WM_BYTE_SELECT;
    always @(posedge clk) begin
        if (!rst_n) begin
            ctrl    <= `EMB_CTRL_RST;
            cw      <= 1'b0;
            even_op <= 1'b0;
            held    <= 8'h00;
        end else begin
            cw <= haddr_sel && htrans[1] && hwrite && haddr == `EMB_ADDR_CTRL;
            if (cw) ctrl <= hwdata[7:0];
            if (op_req && op_write && ww && !table_pointer[0]) begin
                even_op <= 1'b1;
                held    <= table_latch_byte;
            end else if (op_done) even_op <= 1'b0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_wrl_unused: assert property (!write_low_strobe_n |-> !ww && !bs)
        else $error("low write strobe used");
    a_ww_both_sel: assert property (ww && !write_high_strobe_n |-> !upper_byte_select_n && !lower_byte_select_n)
        else $error("byte selects not both active");
    a_ww_odd_data: assert property (ww && !write_high_strobe_n |-> muxed_bus_lines == {table_latch_byte, held} && byte_address_lsb)
        else $error("odd word write data wrong");
    a_ww_even_quiet: assert property (even_op |-> write_high_strobe_n && write_low_strobe_n)
        else $error("strobe on even write");
    a_bs_halves: assert property (bs && !write_high_strobe_n |-> muxed_bus_lines == {2{table_latch_byte}} && byte_address_lsb == table_pointer[0] && upper_byte_select_n != lower_byte_select_n)
        else $error("byte select write wrong");
    a_freeze_hold: assert property (sleep_req [*3] |-> $stable(muxed_bus_lines) && $stable(bus_oe_n) && $stable(addr_latch))
        else $error("bus moved while frozen");
    a_freeze_high: assert property (sleep_req [*3] |-> chip_enable_n && upper_byte_select_n && lower_byte_select_n)
        else $error("enables not high while frozen");
    a_ce_active: assert property ((!write_high_strobe_n || !output_enable_n) && !sleep_req && !$past(sleep_req) && !$past(sleep_req, 2) |-> !chip_enable_n)
        else $error("access without chip enable");
    a_done_bound: assert property (op_req && !op_done |-> ##[1:DMAX] op_done)
        else $error("operation did not finish");
    a_idle_release: assert property (op_done ##1 (!op_req && !sleep_req) |=> &bus_oe_n && chip_enable_n && write_high_strobe_n && !addr_latch && !byte_address_lsb)
        else $error("bus not released when idle");
    c_ww_write: cover property (ww && !write_high_strobe_n);
    c_bs_write: cover property (bs && !write_high_strobe_n);
    c_frozen: cover property (sleep_req [*3]);
endmodule
bind emb_bus emb_bus_sva #(.TCY(TCY)) i_sva (.*);

// [tb.sv]
// testbench for the external memory bus block
`timescale 1ns/1ps
`include "emb_regs.vh"
module tb;
    localparam TCY = `EMB_TCY_CYCLES;
    reg         clk = 1'b0, rst_n = 1'b0, haddr_sel = 1'b0, hwrite = 1'b0, op_req = 1'b0;
    reg         op_write = 1'b0, op_fetch = 1'b0, sleep_req = 1'b0;
    reg  [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    reg  [1:0]  htrans = 2'h0, sel;
    reg  [2:0]  hsize = 3'h2;
    reg  [20:0] table_pointer = 21'h0;
    reg  [7:0]  table_latch_byte = 8'h0;
    reg  [15:0] wv, snap;
    reg         ba, pb;
    wire [31:0] hrdata;
    wire        hready, hreadyout, hresp, op_done, addr_latch, chip_enable_n;
    wire        output_enable_n, write_high_strobe_n, write_low_strobe_n, byte_address_lsb;
    wire        upper_byte_select_n, lower_byte_select_n;
    wire [15:0] op_rdata, bus_in, muxed_bus_lines, bus_oe_n;
    integer     fail_count = 0, compares = 0, len, seen, wl, tg, base, w;
    assign hready = hreadyout;
    always #2.5 clk = ~clk;
    emb_bus #(.TCY(TCY)) i_dut (.*);
    emb_mem_model i_mem (.*);
    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task ahb(input wr, input [31:0] a, input [31:0] d);
        begin
            haddr_sel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= wr;
            haddr <= a;
            @(posedge clk);
            while (hready !== 1'b1) @(posedge clk);
            haddr_sel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge clk);
            while (hready !== 1'b1) @(posedge clk);
            rd = hrdata;
        end
    endtask
    task op(input wr, input f, input [20:0] p, input [7:0] b);
        begin
            op_write <= wr;
            op_fetch <= f;
            table_pointer <= p;
            table_latch_byte <= b;
            op_req <= 1'b1;
            @(posedge clk);
            op_req <= 1'b0;
            len = 0;
            seen = 0;
            wl = 0;
            tg = 0;
            pb = byte_address_lsb;
            while (op_done !== 1'b1) begin
                @(posedge clk);
                len = len + 1;
                if (write_high_strobe_n === 1'b0) begin
                    seen = seen + 1;
                    wv = muxed_bus_lines;
                    sel = {upper_byte_select_n, lower_byte_select_n};
                    ba = byte_address_lsb;
                end
                if (write_low_strobe_n === 1'b0) wl = wl + 1;
                if (byte_address_lsb !== pb) tg = tg + 1;
                pb = byte_address_lsb;
            end
        end
    endtask
    task end_of_test;
        begin
            $display("compares=%0d fail_count=%0d", compares, fail_count);
            if (fail_count == 0 && compares > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task t_regs;
        begin
            ahb(1'b0, `EMB_ADDR_CTRL, 32'h0);
            chk(rd, 32'h30);
            chk({hreadyout, hresp}, 2'h2);
            ahb(1'b0, 32'h40, 32'h0);
            chk(rd, 32'h0);
        end
    endtask
    task t_word;
        begin
            ahb(1'b1, `EMB_ADDR_CTRL, 32'h01);
            op(1'b1, 1'b0, 21'h100, 8'ha5);
            chk(seen + wl, 0);
            op(1'b1, 1'b0, 21'h101, 8'h3c);
            chk(wv, 16'h3ca5);
            chk({sel, ba}, 3'h1);
            chk(wl, 0);
        end
    endtask
    task t_bsel;
        begin
            ahb(1'b1, `EMB_ADDR_CTRL, 32'h02);
            op(1'b1, 1'b0, 21'h103, 8'h5e);
            chk(wv, 16'h5e5e);
            chk({^sel, ba}, 2'h3);
            chk(wl, 0);
        end
    endtask
    task t_wait;
        begin
            ahb(1'b1, `EMB_ADDR_CTRL, 32'h31);
            op(1'b0, 1'b0, 21'h100, 8'h0);
            chk(op_rdata, 16'h3ca5);
            base = len;
            for (w = 0; w < 4; w = w + 1) begin
                ahb(1'b1, `EMB_ADDR_CTRL, 32'h41 | (w << 4));
                op(1'b0, 1'b0, 21'h100, 8'h0);
                chk(len - base, w * TCY);
            end
        end
    endtask
    task t_bus8;
        begin
            ahb(1'b1, `EMB_ADDR_CTRL, 32'h82);
            op(1'b0, 1'b1, 21'h102, 8'h0);
            chk(len - base, TCY / 2);
            chk(op_rdata, 16'h5e00);
            chk(tg != 0, 1);
        end
    endtask
    task t_sleep;
        begin
            ahb(1'b1, `EMB_ADDR_CTRL, 32'h01);
            fork
                op(1'b0, 1'b0, 21'h100, 8'h0);
                begin
                    repeat (4) @(posedge clk);
                    sleep_req <= 1'b1;
                    repeat (3) @(posedge clk);
                    snap = muxed_bus_lines;
                    repeat (5) @(posedge clk);
                    chk(muxed_bus_lines, snap);
                    chk({chip_enable_n, upper_byte_select_n, lower_byte_select_n}, 3'h7);
                    sleep_req <= 1'b0;
                end
            join
        end
    endtask
    initial begin
        #(5 * 5000);
        fail_count = fail_count + 1;
        end_of_test;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs;
        t_word;
        t_bsel;
        t_wait;
        t_bus8;
        t_sleep;
        end_of_test;
    end
endmodule
